// *** design/spa_pkg.sv ***
// constants and types for the slave port priority arbiter
package spa_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_MASTERS  = 5;
    localparam int FIELD_STRIDE = 4;
    localparam int LVL_W        = 2;
    localparam int IDX_W        = 3;
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 32;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [ADDR_W-1:0] PRIO_OFFSET   = 8'h84;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h88;
    localparam logic [ADDR_W-1:0] WPMR_OFFSET   = 8'he4;

    localparam logic [DATA_W-1:0] PRIO_RESET    = 32'h0000_0222;
    localparam logic [DATA_W-1:0] PRIO_MASK     = 32'h0003_3333;
    localparam logic              WP_EN_RESET    = 1'h0;
    localparam int                WP_EN_BIT      = 0;
    localparam int                STAT_OWNED_BIT = 0;
    localparam int                STAT_IDX_LSB   = 4;
    localparam int                STAT_WP_EN_BIT = 8;

    // ************************************************************
    // pool levels
    // ************************************************************
    localparam logic [LVL_W-1:0] LVL_RR_LOW  = 2'h0;
    localparam logic [LVL_W-1:0] LVL_RR_HIGH = 2'h3;
    localparam logic [IDX_W-1:0] PTR_RESET   = 3'h0;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_OWNED = 2'b10
    } spa_arb_state_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } spa_apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } spa_apb_rsp_t;

    typedef struct packed {
        logic [DATA_W-1:0]      prio;
        logic                   write_protect_enable;
        spa_arb_state_t         st;
        logic [NUM_MASTERS-1:0] grant;
        logic [IDX_W-1:0]       owner;
        logic [IDX_W-1:0]       ptr_low;
        logic [IDX_W-1:0]       ptr_high;
        logic [DATA_W-1:0]      rdata;
        logic                   slverr;
    } spa_state_t;

endpackage : spa_pkg

// *** design/spa_rr_pick.sv ***
// round-robin picker: first set mask bit after the last grantee
`timescale 1ns/1ns
module spa_rr_pick #(
    parameter int N  = 5,
    parameter int IW = 3
) (
    input  wire logic [N-1:0]  mask_in,
    input  wire logic [IW-1:0] last_in,
    output logic      [N-1:0]  pick_out,
    output logic      [IW-1:0] idx_out
);
    always_comb begin
        int j;
        logic found;
        j        = 0;
        found    = 1'b0;
        pick_out = '0;
        idx_out  = '0;
        // search starts one past the last grantee so everyone gets a turn
        for (int k = 1; k <= N; k++) begin
            j = (int'(last_in) + k) % N;
            if (!found && mask_in[j]) begin
                found       = 1'b1;
                pick_out[j] = 1'b1;
                idx_out     = IW'(j);
            end
        end
    end
endmodule : spa_rr_pick

// *** design/spa_fixed_pick.sv ***
// fixed-order picker: lowest set mask bit wins
`timescale 1ns/1ns
module spa_fixed_pick #(
    parameter int N  = 5,
    parameter int IW = 3
) (
    input  wire logic [N-1:0]  mask_in,
    output logic      [N-1:0]  pick_out,
    output logic      [IW-1:0] idx_out
);
    always_comb begin
        logic found;
        found    = 1'b0;
        pick_out = '0;
        idx_out  = '0;
        for (int k = 0; k < N; k++) begin
            if (!found && mask_in[k]) begin
                found       = 1'b1;
                pick_out[k] = 1'b1;
                idx_out     = IW'(k);
            end
        end
    end
endmodule : spa_fixed_pick

// *** design/spa_arbiter.sv ***
// slave port priority arbiter with apb register slave
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
module spa_arbiter (
    input  wire logic                             ref_clk_in,
    input  wire logic                             rst_in,
    input  wire logic                             psel_in,
    input  wire logic                             penable_in,
    input  wire logic                             pwrite_in,
    input  wire logic [spa_pkg::ADDR_W-1:0]       paddr_in,
    input  wire logic [spa_pkg::DATA_W-1:0]       pwdata_in,
    output logic      [spa_pkg::DATA_W-1:0]       prdata_out,
    output logic                                  pready_out,
    output logic                                  pslverr_out,
    input  wire logic [spa_pkg::NUM_MASTERS-1:0]  req_in,
    output logic      [spa_pkg::NUM_MASTERS-1:0]  grant_out,
    output logic                                  grant_valid_out
);
    import spa_pkg::*;

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == PRIO_OFFSET) || (a == STATUS_OFFSET) || (a == WPMR_OFFSET);
    endfunction : is_mapped

    function automatic logic [DATA_W-1:0] read_value(input logic [ADDR_W-1:0] a,
                                                     input spa_state_t s);
        read_value = '0;
        case (a)
            PRIO_OFFSET: begin
                read_value = s.prio & PRIO_MASK;
            end
            WPMR_OFFSET: begin
                read_value[WP_EN_BIT] = s.write_protect_enable;
            end
            STATUS_OFFSET: begin
                read_value[STAT_OWNED_BIT]                 = (s.st == ST_OWNED);
                read_value[STAT_IDX_LSB +: IDX_W]          = s.owner;
                read_value[STAT_WP_EN_BIT]                 = s.write_protect_enable;
            end
            default: begin
                read_value = '0;
            end
        endcase
    endfunction : read_value

    // ************************************************************
    // state
    // ************************************************************
    spa_state_t   st;
    spa_state_t   next_st;
    spa_apb_req_t apb;
    spa_apb_rsp_t rsp;

    assign apb = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
                   paddr: paddr_in, pwdata: pwdata_in};

    logic setup_cyc;
    logic access_cyc;
    assign setup_cyc  = apb.psel && !apb.penable;
    assign access_cyc = apb.psel && apb.penable;

    // ************************************************************
    // level fields
    // ************************************************************
    logic [LVL_W-1:0]       lvl [NUM_MASTERS];
    logic [NUM_MASTERS-1:0] pool;
    logic [LVL_W-1:0]       best_lvl;

    genvar g;
    generate
        for (g = 0; g < NUM_MASTERS; g++) begin : g_lvl
            assign lvl[g]  = st.prio[g*FIELD_STRIDE +: LVL_W];
            assign pool[g] = req_in[g] && (lvl[g] == best_lvl);
        end
    endgenerate

    // highest programmed level among requesters
    always_comb begin
        best_lvl = '0;
        for (int i = 0; i < NUM_MASTERS; i++) begin
            if (req_in[i] && (lvl[i] > best_lvl)) begin
                best_lvl = lvl[i];
            end
        end
    end

    // ************************************************************
    // pool pickers
    // ************************************************************
    logic                   rr_pool;
    logic [IDX_W-1:0]       rr_last;
    logic [NUM_MASTERS-1:0] rr_pick;
    logic [IDX_W-1:0]       rr_idx;
    logic [NUM_MASTERS-1:0] fx_pick;
    logic [IDX_W-1:0]       fx_idx;
    logic [NUM_MASTERS-1:0] choice;
    logic [IDX_W-1:0]       choice_idx;

    assign rr_pool = (best_lvl == LVL_RR_LOW) || (best_lvl == LVL_RR_HIGH);
    // each rotating pool keeps its own pointer so they do not disturb each other
    assign rr_last = (best_lvl == LVL_RR_HIGH) ? st.ptr_high : st.ptr_low;

    spa_rr_pick #(
        .N  (NUM_MASTERS),
        .IW (IDX_W)
    ) u_spa_rr_pick (
        .mask_in  (pool),
        .last_in  (rr_last),
        .pick_out (rr_pick),
        .idx_out  (rr_idx)
    );

    spa_fixed_pick #(
        .N  (NUM_MASTERS),
        .IW (IDX_W)
    ) u_spa_fixed_pick (
        .mask_in  (pool),
        .pick_out (fx_pick),
        .idx_out  (fx_idx)
    );

    assign choice     = rr_pool ? rr_pick : fx_pick;
    assign choice_idx = rr_pool ? rr_idx  : fx_idx;

    // ************************************************************
    // ownership
    // ************************************************************
    logic owner_req;
    logic arb_go;
    assign owner_req = |(req_in & st.grant);
    // an owner keeps the port until it drops its request, no preemption
    assign arb_go    = (st.st == ST_IDLE) || !owner_req;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_st = st;
        if (setup_cyc) begin
            next_st.rdata  = read_value(apb.paddr, st);
            next_st.slverr = !is_mapped(apb.paddr);
        end
        if (access_cyc && apb.pwrite) begin
            if ((apb.paddr == PRIO_OFFSET) && !st.write_protect_enable) begin
                next_st.prio = apb.pwdata & PRIO_MASK;
            end
            if (apb.paddr == WPMR_OFFSET) begin
                next_st.write_protect_enable = apb.pwdata[WP_EN_BIT];
            end
        end
        case (st.st)
            ST_IDLE, ST_OWNED: begin
                if (arb_go) begin
                    if (|req_in) begin
                        next_st.st    = ST_OWNED;
                        next_st.grant = choice;
                        next_st.owner = choice_idx;
                        if (best_lvl == LVL_RR_HIGH) begin
                            next_st.ptr_high = choice_idx;
                        end else if (best_lvl == LVL_RR_LOW) begin
                            next_st.ptr_low = choice_idx;
                        end
                    end else begin
                        next_st.st    = ST_IDLE;
                        next_st.grant = '0;
                    end
                end
            end
            default: begin
                next_st.st    = ST_IDLE;
                next_st.grant = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st.prio     <= PRIO_RESET;
            st.write_protect_enable <= WP_EN_RESET;
            st.st       <= ST_IDLE;
            st.grant    <= '0;
            st.owner    <= PTR_RESET;
            st.ptr_low  <= PTR_RESET;
            st.ptr_high <= PTR_RESET;
            st.rdata    <= '0;
            st.slverr   <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // zero wait states: read data is captured during the setup cycle
    assign rsp.prdata  = st.rdata;
    assign rsp.pready  = access_cyc;
    assign rsp.pslverr = access_cyc && st.slverr;

    assign prdata_out      = rsp.prdata;
    assign pready_out      = rsp.pready;
    assign pslverr_out     = rsp.pslverr;
    assign grant_out       = st.grant;
    assign grant_valid_out = (st.st == ST_OWNED);

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    logic prio_wr;
    assign prio_wr = access_cyc && apb.pwrite && (apb.paddr == PRIO_OFFSET);

    logic [LVL_W-1:0] grant_lvl;
    assign grant_lvl = lvl[st.owner];

    property p_wp_block;
        prio_wr && st.write_protect_enable |=> $stable(st.prio);
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("priority write passed write protect");

    property p_wp_accept;
        prio_wr && !st.write_protect_enable |=> st.prio == ($past(apb.pwdata) & PRIO_MASK);
    endproperty
    a_wp_accept: assert property (p_wp_accept) else $error("priority write lost while unprotected");

    property p_field_read;
        setup_cyc && !apb.pwrite && (apb.paddr == PRIO_OFFSET) ##1 access_cyc
            |-> prdata_out[13:12] == lvl[3] && prdata_out[17:16] == lvl[4] && prdata_out[31:18] == '0;
    endproperty
    a_field_read: assert property (p_field_read) else $error("priority field layout wrong");

    property p_best_wins;
        arb_go && (|req_in) |=> grant_valid_out && grant_lvl == $past(best_lvl) && $onehot(grant_out);
    endproperty
    a_best_wins: assert property (p_best_wins) else $error("lower level master granted");

    property p_pool_member;
        arb_go && (|req_in) |=> (grant_out & $past(pool)) == grant_out;
    endproperty
    a_pool_member: assert property (p_pool_member) else $error("grant outside winning pool");

    property p_rr_rotate;
        arb_go && (|req_in) && (best_lvl == LVL_RR_HIGH) && $countones(pool) > 1
            |=> st.owner != $past(st.ptr_high) && st.ptr_high == st.owner;
    endproperty
    a_rr_rotate: assert property (p_rr_rotate) else $error("round robin did not rotate");

    property p_fixed_order;
        arb_go && (|req_in) && !rr_pool |=> grant_out == ($past(pool) & (~$past(pool) + 5'h01));
    endproperty
    a_fixed_order: assert property (p_fixed_order) else $error("fixed pool order broken");

    property p_fixed_tie;
        arb_go && !rr_pool && pool[0] |=> grant_out[0] ##1 (grant_out[0] || !$past(req_in[0]));
    endproperty
    a_fixed_tie: assert property (p_fixed_tie) else $error("lowest index did not win tie");

    property p_field_read_low;
        setup_cyc && !apb.pwrite && (apb.paddr == PRIO_OFFSET) ##1 access_cyc
            |-> prdata_out[1:0] == lvl[0] && prdata_out[5:4] == lvl[1] && prdata_out[9:8] == lvl[2];
    endproperty
    a_field_read_low: assert property (p_field_read_low) else $error("low priority fields misplaced");

    property p_wp_mode_write;
        access_cyc && apb.pwrite && (apb.paddr == WPMR_OFFSET)
            |=> st.write_protect_enable == $past(apb.pwdata[WP_EN_BIT]);
    endproperty
    a_wp_mode_write: assert property (p_wp_mode_write) else $error("write protect bit not stored");

    // catches a stray path, e.g. an unmapped address aliasing the level register
    property p_prio_write_only;
        !prio_wr |=> $stable(st.prio);
    endproperty
    a_prio_write_only: assert property (p_prio_write_only) else $error("levels changed without a write");

    property p_rr_rotate_low;
        arb_go && (|req_in) && (best_lvl == LVL_RR_LOW) && $countones(pool) > 1
            |=> st.owner != $past(st.ptr_low) && st.ptr_low == st.owner;
    endproperty
    a_rr_rotate_low: assert property (p_rr_rotate_low) else $error("low pool did not rotate");

    property p_rr_separate;
        arb_go && (|req_in) && (best_lvl == LVL_RR_HIGH) |=> $stable(st.ptr_low);
    endproperty
    a_rr_separate: assert property (p_rr_separate) else $error("high pool moved low pointer");

    property p_fixed_no_rotate;
        arb_go && (|req_in) && !rr_pool |=> $stable(st.ptr_low) && $stable(st.ptr_high);
    endproperty
    a_fixed_no_rotate: assert property (p_fixed_no_rotate) else $error("fixed pool moved a pointer");

    // no preemption: a higher level request waits for the owner to let go
    property p_owner_kept;
        grant_valid_out && owner_req |=> $stable(grant_out);
    endproperty
    a_owner_kept: assert property (p_owner_kept) else $error("owner lost port while requesting");

    property p_single_owner;
        grant_valid_out |-> $onehot(grant_out);
    endproperty
    a_single_owner: assert property (p_single_owner) else $error("grant not one master");

endmodule : spa_arbiter

// *** verif/spa_master_model.sv ***
// bus master model: each master requests once per start pulse
`timescale 1ns/1ns
module spa_master_model (
    input  wire logic                            ref_clk_in,
    input  wire logic                            rst_in,
    input  wire logic                            start_in,
    input  wire logic [1:0]                      hold_in,
    input  wire logic [spa_pkg::NUM_MASTERS-1:0] grant_in,
    output logic      [spa_pkg::NUM_MASTERS-1:0] req_out
);
    import spa_pkg::*;

    // ************************************************************
    // request hold and release
    // ************************************************************
    logic [1:0] hold_cnt;

    // hold_in of 0 releases at once, larger values model slow masters
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_out  <= '0;
            hold_cnt <= 2'h0;
        end else if (start_in) begin
            req_out  <= '1;
            hold_cnt <= 2'h0;
        end else if (|(grant_in & req_out)) begin
            if (hold_cnt == hold_in) begin
                req_out  <= req_out & ~grant_in;
                hold_cnt <= 2'h0;
            end else begin
                hold_cnt <= hold_cnt + 2'h1;
            end
        end
    end
endmodule : spa_master_model

// *** verif/spa_arbiter_tb_top.sv ***
// self-checking bench for the slave port priority arbiter
`timescale 1ns/1ns
module spa_arbiter_tb_top;
    import spa_pkg::*;

    // ************************************************************
    // signals
    // ************************************************************
    logic                   ref_clk_in = 1'b0;
    logic                   rst_in     = 1'b1;
    logic                   psel_in    = 1'b0;
    logic                   penable_in = 1'b0;
    logic                   pwrite_in  = 1'b0;
    logic [ADDR_W-1:0]      paddr_in   = 8'h00;
    logic [DATA_W-1:0]      pwdata_in  = 32'h0;
    logic [DATA_W-1:0]      prdata_out;
    logic                   pready_out;
    logic                   pslverr_out;
    logic [NUM_MASTERS-1:0] req_in;
    logic [NUM_MASTERS-1:0] grant_out;
    logic                   grant_valid_out;
    logic                   start_in   = 1'b0;
    logic [1:0]             hold_in    = 2'h0;
    logic [NUM_MASTERS-1:0] prev_gnt;
    logic [DATA_W-1:0]      rnd;
    logic [DATA_W:0]        rd_q[$];
    logic [NUM_MASTERS-1:0] gnt_q[$];
    int                     fail_count = 0;
    int                     cmp_count  = 0;
    int                     cyc        = 0;

    always #25 ref_clk_in = ~ref_clk_in;

    spa_arbiter u_spa_arbiter (
        .ref_clk_in      (ref_clk_in),
        .rst_in          (rst_in),
        .psel_in         (psel_in),
        .penable_in      (penable_in),
        .pwrite_in       (pwrite_in),
        .paddr_in        (paddr_in),
        .pwdata_in       (pwdata_in),
        .prdata_out      (prdata_out),
        .pready_out      (pready_out),
        .pslverr_out     (pslverr_out),
        .req_in          (req_in),
        .grant_out       (grant_out),
        .grant_valid_out (grant_valid_out)
    );

    spa_master_model u_spa_master_model (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .start_in   (start_in),
        .hold_in    (hold_in),
        .grant_in   (grant_out),
        .req_out    (req_in)
    );

    // ************************************************************
    // compare tasks and result watcher
    // ************************************************************
    task automatic check_rd(input logic [DATA_W:0] e, input logic [DATA_W:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED read expected %h seen %h", e, g);
        end
    endtask : check_rd

    task automatic check_gnt(input logic [NUM_MASTERS-1:0] e, input logic [NUM_MASTERS-1:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED grant expected %h seen %h", e, g);
        end
    endtask : check_gnt

    task automatic check_valid(input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED grant valid expected %b seen %b", e, g);
        end
    endtask : check_valid

    // oldest note is taken whenever a read completes or a new grant shows
    always @(posedge ref_clk_in) begin
        prev_gnt <= grant_out;
        if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in) begin
            check_rd(rd_q.pop_front(), {pslverr_out, prdata_out});
        end
        if (grant_out !== prev_gnt && grant_out !== 5'h0) begin
            check_gnt(gnt_q.pop_front(), grant_out);
            check_valid(1'b1, grant_valid_out);
        end
        if (grant_out === 5'h0 && (|prev_gnt) === 1'b1) begin
            check_valid(1'b0, grant_valid_out);
        end
    end

    // ************************************************************
    // drivers
    // ************************************************************
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= w;
        paddr_in   <= a;
        pwdata_in  <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        // only the bench timeout ends a wait for pready
        do begin
            @(posedge ref_clk_in);
        end while (pready_out !== 1'b1);
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        @(posedge ref_clk_in);
    endtask : apb

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // ord holds five 3-bit master indices, first grant in the top field
    task automatic run_arb(input logic [DATA_W-1:0] pr, input logic [14:0] ord);
        apb(1'b1, PRIO_OFFSET, pr);
        for (int i = 0; i < NUM_MASTERS; i++) begin
            gnt_q.push_back(5'h1 << ord[14-3*i -: 3]);
        end
        hold_in  <= 2'($urandom_range(3, 0));
        start_in <= 1'b1;
        @(posedge ref_clk_in);
        start_in <= 1'b0;
        while (gnt_q.size() != 0 || req_in !== 5'h0) begin
            @(posedge ref_clk_in);
        end
        repeat (2) @(posedge ref_clk_in);
        $display("arbitration test done, levels %h", pr);
    endtask : run_arb

    task automatic test_done;
        if (rd_q.size() != 0 || gnt_q.size() != 0) fail_count++;
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // hang guard: whole run needs well under a thousand cycles
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            test_done();
        end
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (12) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        void'($urandom(42));
        @(posedge ref_clk_in);
        rd(PRIO_OFFSET, {1'b0, PRIO_RESET});
        rd(WPMR_OFFSET, 33'h0);
        rd(STATUS_OFFSET, 33'h0);
        $display("reset value test done");
        rnd = $urandom;
        apb(1'b1, PRIO_OFFSET, rnd);
        rd(PRIO_OFFSET, {1'b0, rnd & PRIO_MASK});
        $display("level field test done");
        apb(1'b1, WPMR_OFFSET, 32'h1);
        apb(1'b1, PRIO_OFFSET, ~rnd);
        rd(PRIO_OFFSET, {1'b0, rnd & PRIO_MASK});
        rd(STATUS_OFFSET, 33'h100);
        rd(WPMR_OFFSET, 33'h1);
        apb(1'b1, WPMR_OFFSET, 32'h0);
        apb(1'b1, PRIO_OFFSET, ~rnd);
        rd(PRIO_OFFSET, {1'b0, ~rnd & PRIO_MASK});
        rd(8'h40, {1'b1, 32'h0});
        $display("write protect test done");
        run_arb(32'h0003_3333, {3'd1, 3'd2, 3'd3, 3'd4, 3'd0});
        run_arb(32'h0000_0000, {3'd1, 3'd2, 3'd3, 3'd4, 3'd0});
        run_arb(32'h0002_2222, {3'd0, 3'd1, 3'd2, 3'd3, 3'd4});
        run_arb(32'h0001_1111, {3'd0, 3'd1, 3'd2, 3'd3, 3'd4});
        run_arb(32'h0003_0321, {3'd2, 3'd4, 3'd1, 3'd0, 3'd3});
        test_done();
    end
endmodule : spa_arbiter_tb_top
